// File: rtl/bus_sizing_bridge.sv
// Bus cycle sequencer with dynamic 16/32 bit data bus sizing.
// Summary of operation
// RULE1: Slave reports port width every cycle.
// RULE2: Half port splits wide or straddling transfers.
// RULE3: Half port transfers use only lower lines.
// RULE4: Width input ignored without lanes 2/3.
// RULE5: Classify upper-only versus upper-and-lower cycles.
// RULE6: Upper-only half read takes lower lines.
// RULE7: Upper-only writes duplicate upper data downward.
// RULE8: Split read: low bytes first, then high.
// RULE9: Second split cycle keeps lanes 0/1 off.
// RULE10: Split write: full word, then duplicated high.
// RULE11: Slave holds half width in second cycle.
// RULE12: Full width array never reports half width.
// RULE13: Decoder reports half width only there.
// RULE14: Split transfers send low-order part first.
// RULE15: Never empty or non-contiguous lane patterns.
// RULE16: Adapter low byte select from lanes.
// RULE17: Adapter high byte select from lanes.
// RULE18: Adapter word bit high for odd words.
// RULE19: 32-bit data, 30 address lines, 4 selects.
// RULE20: Each lane select marks its data byte.
// RULE21: Every cycle waits for ready acknowledge.
// RULE22: Address and definition stable across split.
`timescale 1ns/100ps
module bus_sizing_bridge (
	input wire logic clk_sys, // System clock, 40 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic req_valid, // Core asks for one bus word transfer.
	input wire logic [29:0] req_addr, // Core word address.
	input wire logic [3:0] req_lanes, // Core active-high byte lanes.
	input wire logic req_write, // Core transfer is a write.
	input wire logic [31:0] req_wdata, // Core write word.
	output logic req_busy, // Sequencer is running a transfer.
	output logic done, // One-cycle pulse when transfer ends.
	output logic bad_lanes, // One-cycle pulse, lane pattern refused.
	output logic [31:0] rdata, // Assembled read word.
	output logic [29:0] addr_out, // Upper-order address lines.
	output logic lane0_select_n, // Lane 0 select, active low.
	output logic lane1_select_n, // Lane 1 select, active low.
	output logic lane2_select_n, // Lane 2 select, active low.
	output logic lane3_select_n, // Lane 3 select, active low.
	output logic write_out, // Cycle definition, high for write.
	output logic addr_strobe_n, // Address strobe, active low.
	output logic [31:0] data_out, // Data bus output value.
	output logic data_oe, // Data bus output enable, high drives.
	input wire logic [31:0] data_in, // Data bus input value.
	input wire logic ready_n, // Transfer acknowledge, active low.
	input wire logic half_width_port_n // Port is 16 bits wide, active low.
);
	// Lane pattern is non-empty and contiguous.
	function automatic logic lanes_legal(input logic [3:0] l);
		case (l)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF: lanes_legal = 1'b1;
			default: lanes_legal = 1'b0;
		endcase
	endfunction

	// Expand lanes to a byte mask.
	function automatic logic [31:0] lane_mask(input logic [3:0] l);
		lane_mask = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
	endfunction

	bus_sizing_pkg::seq_state_t state_ff, nxt_state; // Sequencer state.
	logic [3:0] lanes_ff; // Active-high lanes on the bus now.
	logic [31:0] wdata_ff; // Latched core write word.
	logic [3:0] lanes_n; // Lane selects as a vector.
	lane_steer_if ls(); // Steering carrier.

	lane_steer u_steer (
		.ls(ls)
	);

	// Width input counts only when lanes 2 or 3 take part.
	wire half_eff = ~half_width_port_n & (lanes_ff[2] | lanes_ff[3]); // RULE4 RULE1
	// Cycle covers both halves when lanes 1 and 2 are both active.
	wire both_halves = lanes_ff[1] & lanes_ff[2]; // RULE5
	wire acked = ~ready_n; // Slave acknowledges this cycle.
	wire need_split = half_eff & both_halves; // RULE2
	wire accept = (state_ff == bus_sizing_pkg::ST_IDLE) & req_valid; // New request taken.
	wire legal = lanes_legal(req_lanes); // RULE15
	// First half of a split captures only lanes 0 and 1.
	wire [3:0] cap_lanes = need_split ? (lanes_ff & bus_sizing_pkg::LANES_LOWER) : lanes_ff; // RULE8 RULE14
	wire [31:0] cap_mask = lane_mask(cap_lanes); // RULE20
	wire in_data = (state_ff == bus_sizing_pkg::ST_DATA) | (state_ff == bus_sizing_pkg::ST_DATA2); // Data phase.

	assign ls.req_lanes = state_ff == bus_sizing_pkg::ST_IDLE ? req_lanes : lanes_ff;
	assign ls.cur_lanes = lanes_ff;
	assign ls.half_port = half_eff;
	assign ls.wdata = state_ff == bus_sizing_pkg::ST_IDLE ? req_wdata : wdata_ff;
	assign ls.bus_in = data_in;
	assign lane0_select_n = lanes_n[0];
	assign lane1_select_n = lanes_n[1];
	assign lane2_select_n = lanes_n[2];
	assign lane3_select_n = lanes_n[3];

	// Next state: wait in each data phase until acknowledged.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			bus_sizing_pkg::ST_IDLE: begin
				if (req_valid && legal) begin
					nxt_state = bus_sizing_pkg::ST_ADDR;
				end
			end
			bus_sizing_pkg::ST_ADDR: nxt_state = bus_sizing_pkg::ST_DATA;
			bus_sizing_pkg::ST_DATA: begin
				if (acked) begin // RULE21
					nxt_state = need_split ? bus_sizing_pkg::ST_ADDR2 : bus_sizing_pkg::ST_IDLE; // RULE8 RULE10
				end
			end
			bus_sizing_pkg::ST_ADDR2: nxt_state = bus_sizing_pkg::ST_DATA2;
			bus_sizing_pkg::ST_DATA2: begin
				if (acked) begin // RULE21
					nxt_state = bus_sizing_pkg::ST_IDLE;
				end
			end
			default: nxt_state = bus_sizing_pkg::ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_ff <= bus_sizing_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Address, definition and write word are latched once per request.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			addr_out <= bus_sizing_pkg::ADDR_RST;
			write_out <= 1'b0;
			wdata_ff <= bus_sizing_pkg::DATA_RST;
		end else if (accept && legal) begin // RULE22
			addr_out <= req_addr;
			write_out <= req_write;
			wdata_ff <= req_wdata;
		end
	end

	// Lane selects: full pattern first, upper lanes only in the second half.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lanes_ff <= 4'h0;
			lanes_n <= bus_sizing_pkg::LANES_NONE_N;
		end else if (accept && legal) begin
			lanes_ff <= req_lanes;
			lanes_n <= ~req_lanes; // RULE20 RULE19
		end else if (state_ff == bus_sizing_pkg::ST_DATA && acked && need_split) begin
			lanes_ff <= lanes_ff & bus_sizing_pkg::LANES_UPPER;
			lanes_n <= ~(lanes_ff & bus_sizing_pkg::LANES_UPPER); // RULE9
		end else if (in_data && acked) begin
			lanes_ff <= 4'h0;
			lanes_n <= bus_sizing_pkg::LANES_NONE_N;
		end
	end

	// Address strobe marks the first state of each bus cycle.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			addr_strobe_n <= 1'b1;
		end else begin
			addr_strobe_n <= ~((accept && legal) || (state_ff == bus_sizing_pkg::ST_DATA && acked && need_split));
		end
	end

	// Write data drive: full or duplicated image, then the upper copy.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			data_out <= bus_sizing_pkg::DATA_RST;
			data_oe <= 1'b0;
		end else if (accept && legal) begin
			data_out <= ls.wdata_first; // RULE7 RULE10
			data_oe <= req_write;
		end else if (state_ff == bus_sizing_pkg::ST_DATA && acked && need_split) begin
			data_out <= ls.wdata_second; // RULE10 RULE3
		end else if (in_data && acked) begin
			data_oe <= 1'b0;
		end
	end

	// Read capture: only the lanes of this cycle are updated.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata <= bus_sizing_pkg::DATA_RST;
		end else if (in_data && acked && !write_out) begin
			rdata <= (rdata & ~cap_mask) | (ls.rd_steer & cap_mask); // RULE6 RULE8
		end
	end

	// Handshake flags toward the core.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			done <= 1'b0;
			bad_lanes <= 1'b0;
			req_busy <= 1'b0;
		end else begin
			done <= (in_data && acked && nxt_state == bus_sizing_pkg::ST_IDLE) || (accept && !legal);
			bad_lanes <= accept && !legal; // RULE15
			req_busy <= nxt_state != bus_sizing_pkg::ST_IDLE;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_lanes_legal;
		!addr_strobe_n |-> lanes_legal(~lanes_n);
	endproperty
	a_lanes_legal: assert property (p_lanes_legal) else $error("Illegal lane pattern on bus."); // RULE15

	property p_second_low_off;
		state_ff == bus_sizing_pkg::ST_ADDR2 |-> lanes_n[1:0] == 2'h3 ##1 lanes_n[1:0] == 2'h3;
	endproperty
	a_second_low_off: assert property (p_second_low_off) else $error("Low lanes active in second half."); // RULE9

	property p_split_stable;
		(state_ff == bus_sizing_pkg::ST_DATA && acked && need_split) |=> $stable(addr_out) && $stable(write_out);
	endproperty
	a_split_stable: assert property (p_split_stable) else $error("Address changed inside split."); // RULE22

	property p_upper_dup;
		(data_oe && lanes_n[1:0] == 2'h3 && !addr_strobe_n) |-> data_out[15:0] == data_out[31:16];
	endproperty
	a_upper_dup: assert property (p_upper_dup) else $error("Upper write not duplicated."); // RULE7

	property p_no_split_low;
		(state_ff == bus_sizing_pkg::ST_DATA && acked && lanes_n[3:2] == 2'h3) |=> done;
	endproperty
	a_no_split_low: assert property (p_no_split_low) else $error("Lower-only cycle was split."); // RULE4

	property p_split_seq;
		(state_ff == bus_sizing_pkg::ST_DATA && acked && need_split) |=> !addr_strobe_n ##1 state_ff == bus_sizing_pkg::ST_DATA2;
	endproperty
	a_split_seq: assert property (p_split_seq) else $error("Split second cycle missing."); // RULE8

	property p_second_read;
		(state_ff == bus_sizing_pkg::ST_DATA2 && acked && !write_out && !lanes_n[2]) |=> rdata[23:16] == $past(data_in[7:0]);
	endproperty
	a_second_read: assert property (p_second_read) else $error("Byte 2 not taken from lower lines."); // RULE3

	property p_upper_only_read;
		(state_ff == bus_sizing_pkg::ST_DATA && acked && !write_out && !half_width_port_n && lanes_n == 4'h3)
			|=> rdata[31:16] == $past(data_in[15:0]) && done;
	endproperty
	a_upper_only_read: assert property (p_upper_only_read) else $error("Upper-only half read misplaced."); // RULE6

	property p_first_write_full;
		(state_ff == bus_sizing_pkg::ST_ADDR && write_out && !lanes_n[0]) |-> data_out == wdata_ff;
	endproperty
	a_first_write_full: assert property (p_first_write_full) else $error("First write not full word."); // RULE10

	property p_strobe_one;
		$fell(addr_strobe_n) |=> addr_strobe_n;
	endproperty
	a_strobe_one: assert property (p_strobe_one) else $error("Strobe longer than one cycle."); // RULE19
endmodule

// File: rtl/bus_sizing_pkg.sv
// Shared constants and types for the dynamic bus sizing bridge.
package bus_sizing_pkg;
	localparam int ADDR_W = 30; // Upper-order address lines.
	localparam int DATA_W = 32; // Full data bus width.
	localparam int LANES = 4; // Number of byte lanes.
	localparam logic [3:0] LANES_NONE_N = 4'hF; // All lane selects negated.
	localparam logic [3:0] LANES_UPPER = 4'hC; // Lanes 2 and 3.
	localparam logic [3:0] LANES_LOWER = 4'h3; // Lanes 0 and 1.
	localparam logic [ADDR_W-1:0] ADDR_RST = 30'h0; // Address value after reset.
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0; // Data value after reset.

	// Bus cycle sequencer states, Gray coded along the split path.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_DATA = 3'h3,
		ST_ADDR2 = 3'h2,
		ST_DATA2 = 3'h6
	} seq_state_t;
endpackage

// File: rtl/lane_steer_if.sv
// Carrier between the sequencer and the byte lane steering logic.
`timescale 1ns/100ps
interface lane_steer_if;
	logic [3:0] req_lanes; // Active-high lanes of the word being sent.
	logic [3:0] cur_lanes; // Active-high lanes of the cycle on the bus.
	logic half_port; // Half width port seen in this cycle.
	logic [31:0] wdata; // Write word from the core.
	logic [31:0] wdata_first; // Bus image for the first or only cycle.
	logic [31:0] wdata_second; // Bus image for the second split cycle.
	logic [31:0] bus_in; // Raw bus input.
	logic [31:0] rd_steer; // Read word with lanes steered into place.
	modport seq (output req_lanes, cur_lanes, half_port, wdata, bus_in, input wdata_first, wdata_second, rd_steer);
	modport steer (input req_lanes, cur_lanes, half_port, wdata, bus_in, output wdata_first, wdata_second, rd_steer);
endinterface

// File: rtl/lane_steer.sv
// Byte lane steering for writes and reads on 16 or 32 bit ports.
`timescale 1ns/100ps
module lane_steer (
	lane_steer_if.steer ls // Steering carrier.
);
	// Write touches only the upper half of the word.
	wire req_upper_only = ~ls.req_lanes[0] & ~ls.req_lanes[1] & (ls.req_lanes[2] | ls.req_lanes[3]);
	// Current cycle touches only the upper half.
	wire cur_upper_only = ~ls.cur_lanes[0] & ~ls.cur_lanes[1] & (ls.cur_lanes[2] | ls.cur_lanes[3]);
	// Upper half copied onto the lower data lines.
	wire [31:0] dup_upper = {ls.wdata[31:16], ls.wdata[31:16]};

	// Upper-only writes always carry a copy on the lower lines.
	assign ls.wdata_first = req_upper_only ? dup_upper : ls.wdata; // RULE7
	// Second split write repeats bytes 2 and 3 on the lower lines.
	assign ls.wdata_second = dup_upper; // RULE10
	// A half width port returns the upper bytes on the lower lines.
	assign ls.rd_steer = (ls.half_port && cur_upper_only) ?
		{ls.bus_in[15:0], ls.bus_in[15:0]} : ls.bus_in; // RULE6 RULE3
endmodule

// File: dv/port_model.sv
// Far-side port model: one memory word behind a 16 or 32 bit port.
`timescale 1ns/100ps
module port_model (
	input wire logic clk_sys, // System clock.
	input wire logic addr_strobe_n, // Cycle start, active low.
	input wire logic [3:0] sel_n, // Lane selects, active low.
	input wire logic write_out, // High for write.
	input wire logic [31:0] data_out, // Write data lines.
	input wire logic half, // Behave as a 16 bit port.
	input wire logic [1:0] waits, // Wait states per cycle.
	output logic ready_n, // Acknowledge, active low.
	output logic half_width_port_n, // Width report, active low.
	output logic [31:0] data_in // Read data lines.
);
	logic [31:0] mem = 32'h0; // Stored word.
	logic [31:0] wr_next; // Word after this write.
	logic in_t2 = 1'b0; // Inside the data state.
	logic [1:0] cnt = 2'h0; // Wait states left.
	wire logic word_bit = sel_n[0] & sel_n[1];
	wire logic lower_byte_select_n = ~(~sel_n[0] | (word_bit & ~sel_n[2]));
	wire logic upper_byte_select_n = ~(~sel_n[1] | (word_bit & ~sel_n[3]));
	wire logic [15:0] half_word = word_bit ? mem[31:16] : mem[15:0]; // Half word on the narrow bus.
	// The width is reported in every cycle and held through both split halves.
	assign half_width_port_n = ~half;
	// Acknowledge only once the wait states have run out.
	assign ready_n = ~(in_t2 && cnt == 2'h0);
	// Lines not carrying read data show inverted values so stale data never matches.
	always_comb begin
		if (!in_t2 || write_out) begin
			data_in = ~mem;
		end else if (half) begin
			data_in = {~half_word, half_word};
		end else begin
			data_in = mem;
		end
	end
	// A narrow port only sees the lower lines, steered by its adapter selects.
	always_comb begin
		wr_next = mem;
		for (int i = 0; i < 4; i++) begin
			if (!half && !sel_n[i]) wr_next[8*i +: 8] = data_out[8*i +: 8];
		end
		if (half && !lower_byte_select_n) wr_next[(word_bit ? 16 : 0) +: 8] = data_out[7:0];
		if (half && !upper_byte_select_n) wr_next[(word_bit ? 24 : 8) +: 8] = data_out[15:8];
	end
	// Bus cycle tracking: strobe opens it, acknowledge closes it.
	always @(posedge clk_sys) begin
		if (!addr_strobe_n) begin
			in_t2 <= 1'b1;
			cnt <= waits;
		end else if (in_t2 && cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end else if (in_t2) begin
			in_t2 <= 1'b0;
			if (write_out) mem <= wr_next;
		end
	end
endmodule

// File: dv/tb_top.sv
// Self-checking testbench for the bus sizing bridge.
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 1'b0; // System clock.
	logic reset = 1'b1; // Synchronous reset.
	logic req_valid = 1'b0, req_write = 1'b0, half = 1'b0; // Request and port mode.
	logic [29:0] req_addr = 30'h0; // Word address.
	logic [3:0] req_lanes = 4'h0; // Active lanes.
	logic [31:0] req_wdata = 32'h0; // Write word.
	logic [1:0] waits = 2'h0; // Port wait states.
	logic req_busy, done, bad_lanes, write_out, addr_strobe_n, data_oe, ready_n, half_width_port_n;
	logic [31:0] rdata, data_out, data_in;
	logic [29:0] addr_out;
	wire logic [3:0] sel_n; // Lane selects, active low, driven bit by bit.
	logic [3:0] last_sel; // Selects at the latest strobe.
	logic bad_seen; // Refusal flag seen with done.
	logic [2:0] last_ctl; // Busy, output enable and write at the latest strobe.
	logic [29:0] last_addr; // Address lines at the latest strobe.
	int n_mismatch = 0, tests_run = 0, strobes = 0, lat = 0;
	bus_sizing_bridge u_bus_sizing_bridge (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
		.req_addr(req_addr), .req_lanes(req_lanes), .req_write(req_write), .req_wdata(req_wdata),
		.req_busy(req_busy), .done(done), .bad_lanes(bad_lanes), .rdata(rdata), .addr_out(addr_out),
		.lane0_select_n(sel_n[0]), .lane1_select_n(sel_n[1]), .lane2_select_n(sel_n[2]),
		.lane3_select_n(sel_n[3]), .write_out(write_out), .addr_strobe_n(addr_strobe_n),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in), .ready_n(ready_n),
		.half_width_port_n(half_width_port_n));
	port_model u_port_model (.clk_sys(clk_sys), .addr_strobe_n(addr_strobe_n), .sel_n(sel_n),
		.write_out(write_out), .data_out(data_out), .half(half), .waits(waits), .ready_n(ready_n),
		.half_width_port_n(half_width_port_n), .data_in(data_in));
	// Clock generator.
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Counts bus cycles and keeps the selects of the latest one.
	always @(posedge clk_sys) begin
		if (addr_strobe_n === 1'b0) begin
			strobes++;
			last_sel = sel_n;
			last_ctl = {req_busy, data_oe, write_out};
			last_addr = addr_out;
		end
	end
	// Compares one value and reports a mismatch.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Runs one transfer and waits for its completion pulse.
	task automatic xfer(input logic wr, input logic [3:0] ln, input logic [31:0] wd, input logic hf);
		@(posedge clk_sys);
		#2;
		{req_valid, req_write, req_lanes, req_wdata, half, req_addr} = {1'b1, wr, ln, wd, hf, req_addr + 30'h1};
		strobes = 0;
		@(posedge clk_sys);
		#2;
		req_valid = 1'b0;
		lat = 0;
		while (done !== 1'b1 && lat < 50) begin
			@(posedge clk_sys);
			#2;
			lat++;
		end
		bad_seen = bad_lanes;
		check("done", 32'h1, {31'h0, done});
		check("idle flags", 32'h0, {30'h0, req_busy, data_oe});
		// The last bus cycle of a transfer shows the request's own address and definition.
		if (strobes > 0) begin
			check("cycle ctl", {29'h0, 1'b1, wr, wr}, {29'h0, last_ctl});
			check("cycle addr", {2'h0, req_addr}, {2'h0, last_addr});
		end
	endtask
	// Full width port: plain word write and read, one cycle each.
	task automatic t_full;
		xfer(1'b1, 4'hF, 32'hA1B2C3D4, 1'b0);
		xfer(1'b0, 4'hF, 32'h0, 1'b0);
		check("full rdata", 32'hA1B2C3D4, rdata);
		check("full cycles", 32'h1, strobes);
		$display("test full done");
	endtask
	// Half port: whole word split into two cycles, low part first.
	task automatic t_split;
		xfer(1'b1, 4'hF, 32'h55667788, 1'b1);
		check("split wr cycles", 32'h2, strobes);
		check("second sel", 32'h3, {30'h0, last_sel[1:0]});
		check("split mem", 32'h55667788, u_port_model.mem);
		xfer(1'b0, 4'hF, 32'h0, 1'b1);
		check("split rd cycles", 32'h2, strobes);
		check("split rdata", 32'h55667788, rdata);
		xfer(1'b1, 4'h6, 32'h00ABCD00, 1'b1);
		check("mid cycles", 32'h2, strobes);
		check("mid mem", 32'h55ABCD88, u_port_model.mem);
		$display("test split done");
	endtask
	// Half port: upper-only and lower-only transfers need one cycle.
	task automatic t_half_single;
		xfer(1'b1, 4'hC, 32'hCAFE0000, 1'b1);
		check("upper wr cycles", 32'h1, strobes);
		check("upper mem", 32'hCAFECD88, u_port_model.mem);
		xfer(1'b0, 4'hC, 32'h0, 1'b1);
		check("upper rdata", 32'hCAFE, {16'h0, rdata[31:16]});
		xfer(1'b1, 4'h3, 32'h0000BEEF, 1'b1);
		check("lower cycles", 32'h1, strobes);
		check("lower mem", 32'hCAFEBEEF, u_port_model.mem);
		$display("test half_single done");
	endtask
	// Empty and gapped lane patterns are refused without a bus cycle.
	task automatic t_bad;
		logic [3:0] pats [3] = '{4'h0, 4'h5, 4'h9};
		foreach (pats[i]) begin
			xfer(1'b1, pats[i], 32'h0, 1'b0);
			check("refused", 32'h1, {31'h0, bad_seen});
			check("refused cycles", 32'h0, strobes);
		end
		$display("test bad done");
	endtask
	// Wait states stretch the cycle until acknowledge.
	task automatic t_wait;
		waits = 2'h3;
		xfer(1'b0, 4'hF, 32'h0, 1'b0);
		check("wait latency", 32'h5, lat);
		check("wait rdata", 32'hCAFEBEEF, rdata);
		waits = 2'h0;
		$display("test wait done");
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake.
	initial begin
		#(25 * 3000);
		n_mismatch++;
		end_sim();
	end
	// Main sequence.
	initial begin
		repeat (12) @(posedge clk_sys);
		#2;
		reset = 1'b0;
		t_full();
		t_split();
		t_half_single();
		t_bad();
		t_wait();
		end_sim();
	end
endmodule
